// File: sim/tb.sv
// Purpose: Self-checking bench for the pad pulldown control bank
// Assumes: Bank offsets and masks from ppd_pkg, pads lag inputs by one edge
// Notes: Software writes keep reserved positions zero, so writes are masked
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ppd_pkg::ADDR_W-1:0] reg_addr = 4'h0;
    logic [ppd_pkg::DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ppd_pkg::DATA_W-1:0] reg_rdata;
    logic native_mode = 1'b0;
    logic [ppd_pkg::DATA_W-1:0] pad_avail_two = 32'hffff_ffff;
    logic [ppd_pkg::DATA_W-1:0] pad_avail_three = 32'hffff_ffff;
    logic [ppd_pkg::DATA_W-1:0] pd_on_two;
    logic [ppd_pkg::DATA_W-1:0] pd_on_three;
    logic [ppd_pkg::DATA_W-1:0] m2 = 32'h0;
    logic [ppd_pkg::DATA_W-1:0] m3 = 32'h0;
    logic [ppd_pkg::DATA_W-1:0] pat [4] = '{32'hffff_ffff, 32'h0380_0000, 32'h0001_c100,
        32'h5555_5555};
    int error_cnt = 0;
    int checked = 0;

    always #10 clk = ~clk;

    ppd_bank u_ppd_bank (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .native_mode(native_mode), .pad_avail_two(pad_avail_two),
        .pad_avail_three(pad_avail_three), .pd_on_two(pd_on_two), .pd_on_three(pd_on_three));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Callers clear reserved positions so software never sets them
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a === ppd_pkg::OFF_TWO) m2 = d;
        if (a === ppd_pkg::OFF_THREE) m3 = d;
    endtask

    // Data stand only in the cycle after the strobe, then return to zero
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("read data", reg_rdata, exp);
        @(posedge clk);
        #1;
        check("read idle", reg_rdata, 32'h0);
    endtask

    // Write and read back with no idle cycle between the strobes
    task automatic wr_rd(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("back to back read", reg_rdata, d);
        if (a === ppd_pkg::OFF_TWO) m2 = d;
        if (a === ppd_pkg::OFF_THREE) m3 = d;
    endtask

    // Two edges cover the field flop plus the registered pad stage
    task automatic pads();
        logic ovr;
        repeat (2) @(posedge clk);
        #1;
        ovr = sys_rst | ~native_mode;
        check("pads two", pd_on_two, (ovr ? ppd_pkg::FORCE_TWO : ~m2)
            & ppd_pkg::IMPL_TWO & pad_avail_two);
        check("pads three", pd_on_three, (ovr ? ppd_pkg::FORCE_THREE : ~m3)
            & ppd_pkg::IMPL_THREE & pad_avail_three);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (7) @(posedge clk);
        #1;
        check("reset pads two", pd_on_two, ppd_pkg::FORCE_TWO);
        check("reset pads three", pd_on_three, 32'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        native_mode <= 1'b1;
        rd(ppd_pkg::OFF_TWO, 32'h0);
        rd(ppd_pkg::OFF_THREE, 32'h0);
        pads();
        // Table hits the io3/general io fields, card fields and test pads
        for (int i = 0; i < 4; i++) begin
            wr(ppd_pkg::OFF_TWO, pat[i] & ppd_pkg::IMPL_TWO);
            wr(ppd_pkg::OFF_THREE, ~pat[i] & ppd_pkg::IMPL_THREE);
            rd(ppd_pkg::OFF_TWO, m2);
            rd(ppd_pkg::OFF_THREE, m3);
            pads();
        end
        wr_rd(ppd_pkg::OFF_TWO, 32'h02a5_c182 & ppd_pkg::IMPL_TWO);
        @(posedge clk);
        pad_avail_two <= 32'h00ff_00ff;
        pad_avail_three <= 32'h0000_0f0f;
        pads();
        @(posedge clk);
        native_mode <= 1'b0;
        pads();
        rd(ppd_pkg::OFF_TWO, m2);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h0);
        rd(ppd_pkg::OFF_THREE, m3);
        @(posedge clk);
        native_mode <= 1'b1;
        pads();
        // Second reset in mid-run clears fields and forces the override set
        @(posedge clk);
        sys_rst <= 1'b1;
        m2 = 32'h0;
        m3 = 32'h0;
        pads();
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(ppd_pkg::OFF_TWO, 32'h0);
        pads();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule // tb
`default_nettype wire

// File: src/ppd_bank.sv
// Purpose: Pad pulldown control bank with two software registers
// Assumes: Synchronous reset, single 50 MHz clock, strobe register port
// Notes: Pad outputs lag the field or mode by one clock edge
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Field zero enables pad pulldown, one disables; all fields reset to zero
// - Other pads have pulldown forced off in reset or compatibility mode
// - Register bits act on pads only in native mode
// - Register two bits 25,24,23,22,8,7,5 force pulldown on in reset or compatibility
// - Register three bits 13..10 test pads, 9 config pin, 1 serial2 clear-to-send
// - Card data0, command, data1, data3 fields use the same zero-enables encoding
// - A pad with no pulldown available under muxing gets no pulldown
// - Register two bit 25 processor io3, bits 24 and 23 general io 8, 9
module ppd_bank #(
    parameter int DW = ppd_pkg::DATA_W,
    parameter int AW = ppd_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    input wire logic native_mode,
    input wire logic [DW-1:0] pad_avail_two,
    input wire logic [DW-1:0] pad_avail_three,
    output logic [DW-1:0] pd_on_two,
    output logic [DW-1:0] pd_on_three
);
    logic [ppd_pkg::NUM_REGS-1:0][DW-1:0] ctrl_reg;
    logic [ppd_pkg::NUM_REGS-1:0][DW-1:0] pd_reg;
    logic [ppd_pkg::NUM_REGS-1:0][DW-1:0] avail_all;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;

    function automatic logic addr_hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        return a == off;
    endfunction

    assign avail_all = {pad_avail_three, pad_avail_two};

    genvar g;
    generate
        for (g = 0; g < ppd_pkg::NUM_REGS; g++) begin : g_reg
            ppd_pad_if #(.W(DW)) pads ();

            // Whole word stored, reserved bits too, so readback matches the write
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    ctrl_reg[g] <= ppd_pkg::CTRL_RESET;
                end else if (reg_wr && addr_hit(reg_addr, ppd_pkg::REG_OFF[g])) begin
                    ctrl_reg[g] <= reg_wdata;
                end
            end

            assign pads.field = ctrl_reg[g];
            assign pads.impl_mask = ppd_pkg::IMPL_MASK[g];
            assign pads.force_mask = ppd_pkg::FORCE_MASK[g];
            assign pads.avail = avail_all[g];
            // Reset counts as override so pads sit in the safe pattern meanwhile
            assign pads.override = sys_rst || !native_mode;

            ppd_resolve u_resolve (
                .pads(pads)
            );

            // Registered so no glitch from the mode input reaches a pad
            always_ff @(posedge clk) begin
                pd_reg[g] <= pads.pd_next;
            end
        end
    endgenerate

    assign pd_on_two = pd_reg[0];
    assign pd_on_three = pd_reg[1];

    always_comb begin
        rdata_next = ppd_pkg::RDATA_IDLE;
        for (int i = 0; i < ppd_pkg::NUM_REGS; i++) begin
            if (addr_hit(reg_addr, ppd_pkg::REG_OFF[i])) begin
                rdata_next = ctrl_reg[i];
            end
        end
    end

    // Read data stand one cycle only; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= ppd_pkg::RDATA_IDLE;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= ppd_pkg::RDATA_IDLE;
        end
    end

    assign reg_rdata = rdata_reg;

    property p_reset_clears;
        @(posedge clk) sys_rst |=> (ctrl_reg[0] == ppd_pkg::CTRL_RESET)
                                   && (ctrl_reg[1] == ppd_pkg::CTRL_RESET);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("control not cleared by reset");

    property p_zero_enables;
        @(posedge clk) disable iff (sys_rst)
            (native_mode && pad_avail_two[ppd_pkg::BIT_SERIAL1_RECEIVE]
             && !ctrl_reg[0][ppd_pkg::BIT_SERIAL1_RECEIVE])
            |=> pd_on_two[ppd_pkg::BIT_SERIAL1_RECEIVE];
    endproperty
    a_zero_enables: assert property (p_zero_enables) else $error("zero field gave no pulldown");

    property p_compat_off;
        @(posedge clk) (sys_rst || !native_mode)
            |=> !pd_on_two[ppd_pkg::BIT_SER2_FRAME_SYNC] && !pd_on_three[ppd_pkg::BIT_CONFIG_PIN];
    endproperty
    a_compat_off: assert property (p_compat_off) else $error("plain pad not forced off");

    property p_native_follow;
        @(posedge clk) disable iff (sys_rst)
            native_mode |=> pd_on_two == $past(~ctrl_reg[0] & pad_avail_two & ppd_pkg::IMPL_TWO);
    endproperty
    a_native_follow: assert property (p_native_follow) else $error("pads ignore fields");

    property p_force_on;
        @(posedge clk) (sys_rst || !native_mode)
            |=> (pd_on_two & ppd_pkg::FORCE_TWO) == $past(pad_avail_two & ppd_pkg::FORCE_TWO);
    endproperty
    a_force_on: assert property (p_force_on) else $error("override pad not forced on");

    property p_test_pads;
        @(posedge clk) disable iff (sys_rst)
            native_mode |=> pd_on_three[ppd_pkg::BIT_TEST_RESET:ppd_pkg::BIT_TEST_DATA_IN]
            == $past(~ctrl_reg[1][ppd_pkg::BIT_TEST_RESET:ppd_pkg::BIT_TEST_DATA_IN]
                     & pad_avail_three[ppd_pkg::BIT_TEST_RESET:ppd_pkg::BIT_TEST_DATA_IN]);
    endproperty
    a_test_pads: assert property (p_test_pads) else $error("test pad pulldown wrong");

    property p_card_pads;
        @(posedge clk) disable iff (sys_rst)
            native_mode |=> pd_on_two[ppd_pkg::BIT_CARD_COMMAND]
            == $past(!ctrl_reg[0][ppd_pkg::BIT_CARD_COMMAND]
                     && pad_avail_two[ppd_pkg::BIT_CARD_COMMAND]);
    endproperty
    a_card_pads: assert property (p_card_pads) else $error("card pad encoding wrong");

    property p_unavail;
        @(posedge clk) !pad_avail_two[ppd_pkg::BIT_PROC_IO3] |=> !pd_on_two[ppd_pkg::BIT_PROC_IO3];
    endproperty
    a_unavail: assert property (p_unavail) else $error("pulldown on unavailable pad");

    property p_general_io;
        @(posedge clk) disable iff (sys_rst)
            (native_mode && pad_avail_two[ppd_pkg::BIT_GENERAL_IO8]
             && ctrl_reg[0][ppd_pkg::BIT_GENERAL_IO8])
            |=> !pd_on_two[ppd_pkg::BIT_GENERAL_IO8];
    endproperty
    a_general_io: assert property (p_general_io) else $error("general io8 not disabled");

    sequence s_write_two;
        reg_wr && addr_hit(reg_addr, ppd_pkg::OFF_TWO);
    endsequence
    sequence s_read_two;
        reg_rd && !reg_wr && addr_hit(reg_addr, ppd_pkg::OFF_TWO);
    endsequence
    property p_readback;
        @(posedge clk) disable iff (sys_rst)
            s_write_two ##1 s_read_two |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback differs from write");

    property p_rdata_idle;
        @(posedge clk) disable iff (sys_rst) !reg_rd |=> reg_rdata == ppd_pkg::RDATA_IDLE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    property p_config_pin;
        @(posedge clk) disable iff (sys_rst)
            (native_mode && pad_avail_three[ppd_pkg::BIT_CONFIG_PIN]
             && !ctrl_reg[1][ppd_pkg::BIT_CONFIG_PIN])
            |=> pd_on_three[ppd_pkg::BIT_CONFIG_PIN];
    endproperty
    a_config_pin: assert property (p_config_pin) else $error("config pin pulldown missing");

    property p_serial2_cts;
        @(posedge clk) disable iff (sys_rst)
            (native_mode && pad_avail_three[ppd_pkg::BIT_SERIAL2_CLEAR_TO_SEND]
             && ctrl_reg[1][ppd_pkg::BIT_SERIAL2_CLEAR_TO_SEND])
            |=> !pd_on_three[ppd_pkg::BIT_SERIAL2_CLEAR_TO_SEND];
    endproperty
    a_serial2_cts: assert property (p_serial2_cts) else $error("serial2 cts not disabled");

    property p_card_data3;
        @(posedge clk) disable iff (sys_rst)
            native_mode |=> pd_on_three[ppd_pkg::BIT_CARD_DATA3]
            == $past(!ctrl_reg[1][ppd_pkg::BIT_CARD_DATA3]
                     && pad_avail_three[ppd_pkg::BIT_CARD_DATA3]);
    endproperty
    a_card_data3: assert property (p_card_data3) else $error("card data3 encoding wrong");

    property p_io3_force;
        @(posedge clk) ((sys_rst || !native_mode) && pad_avail_two[ppd_pkg::BIT_PROC_IO3])
            |=> pd_on_two[ppd_pkg::BIT_PROC_IO3];
    endproperty
    a_io3_force: assert property (p_io3_force) else $error("processor io3 not forced on");

    // Reserved positions are stored for readback but must never reach a pad
    property p_reserved_quiet;
        @(posedge clk) disable iff (sys_rst)
            ((pd_on_two & ~ppd_pkg::IMPL_TWO) == '0) && ((pd_on_three & ~ppd_pkg::IMPL_THREE) == '0);
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved bit drives a pad");

    property p_unmapped_read;
        @(posedge clk) disable iff (sys_rst)
            (reg_rd && !addr_hit(reg_addr, ppd_pkg::OFF_TWO) && !addr_hit(reg_addr, ppd_pkg::OFF_THREE))
            |=> reg_rdata == ppd_pkg::RDATA_IDLE;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
endmodule // ppd_bank
`default_nettype wire

// File: src/ppd_pad_if.sv
// Purpose: Carrier between the register bank and the pad resolver
// Assumes: One instance per control register
// Notes: Purely combinational signals
`timescale 1ns/1ns
`default_nettype none
interface ppd_pad_if #(parameter int W = 32);
    logic [W-1:0] field;
    logic [W-1:0] impl_mask;
    logic [W-1:0] force_mask;
    logic [W-1:0] avail;
    logic override;
    logic [W-1:0] pd_next;
    modport bank (output field, output impl_mask, output force_mask, output avail,
                  output override, input pd_next);
    modport res (input field, input impl_mask, input force_mask, input avail,
                 input override, output pd_next);
endinterface
`default_nettype wire

// File: src/ppd_pkg.sv
// Purpose: Shared constants for the pad pulldown control bank
// Assumes: Two 32-bit control registers on a plain strobe port
// Notes: Index 0 of every packed pair is register two, index 1 register three
package ppd_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam int NUM_REGS = 2;

    // Byte offsets of the two control registers
    localparam logic [ADDR_W-1:0] OFF_TWO = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_THREE = 4'h4;
    localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFF = {OFF_THREE, OFF_TWO};

    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

    // Bits that reach a pad; reserved positions never drive a pulldown
    localparam logic [DATA_W-1:0] IMPL_TWO = 32'hffd7_d3a6;
    localparam logic [DATA_W-1:0] IMPL_THREE = 32'h0000_3f03;
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] IMPL_MASK = {IMPL_THREE, IMPL_TWO};

    // Pads whose pulldown is forced on in reset and compatibility mode
    localparam logic [DATA_W-1:0] FORCE_TWO = 32'h03c0_01a0;
    localparam logic [DATA_W-1:0] FORCE_THREE = 32'h0000_0000;
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] FORCE_MASK = {FORCE_THREE, FORCE_TWO};

    // Field positions, register two
    localparam int BIT_PROC_IO3 = 25;
    localparam int BIT_GENERAL_IO8 = 24;
    localparam int BIT_GENERAL_IO9 = 23;
    localparam int BIT_SER2_FRAME_SYNC = 20;
    localparam int BIT_CARD_DATA0 = 16;
    localparam int BIT_CARD_COMMAND = 15;
    localparam int BIT_SERIAL1_RECEIVE = 2;

    // Field positions, register three
    localparam int BIT_TEST_RESET = 13;
    localparam int BIT_TEST_DATA_IN = 10;
    localparam int BIT_CONFIG_PIN = 9;
    localparam int BIT_CARD_DATA3 = 8;
    localparam int BIT_SERIAL2_CLEAR_TO_SEND = 1;
endpackage

// File: src/ppd_resolve.sv
// Purpose: Works out the effective pulldown of every pad of one register
// Assumes: A field of zero asks for the pulldown, one removes it
// Notes: Output is one where the pulldown is applied
`timescale 1ns/1ns
`default_nettype none
module ppd_resolve (
    ppd_pad_if.res pads
);
    // Override picks the forced pattern, else the inverted fields
    always_comb begin
        pads.pd_next = (pads.override ? pads.force_mask : ~pads.field)
                       & pads.impl_mask & pads.avail;
    end
endmodule // ppd_resolve
`default_nettype wire
